// >>> dod_classify.sv
`timescale 1ns/100ps
module dod_classify
    import dod_pkg::*;
(
    // Word in, decode out
    dod_dec_if.dec d
);

    always_comb begin
        d.op               = OP_NONE;
        d.words            = WRD_ONE;
        d.cycles           = CYC_ONE;
        d.auxSel           = d.word[AUX_SEL_LSB +: AUX_SEL_W];
        d.addr             = d.word[ADDR_W-1:0];
        d.imm              = 16'h0000;
        d.shiftFromOperand = 1'b0;
        // Specific encodings sit above the wider patterns they overlap
        casez (d.word)
            // [RULE1] zero constant clears
            16'hb900: d.op = OP_CLEAR_ACC;
            16'hb9??: begin
                d.op  = OP_LOAD_ACC_LOW;
                d.imm = dod_word_t'(d.word[SHORT_IMM_W-1:0]);
            end
            // [RULE2] [RULE3] zeroing loads
            16'h6a??: d.op = OP_ZERO_LOAD_HIGH;
            16'h69??: d.op = OP_ZERO_LOAD_LOW;
            // [RULE4] shift from operand register
            16'h6b??: begin
                d.op               = OP_LOAD_ACC_OPERAND_SHIFT;
                d.shiftFromOperand = 1'b1;
            end
            // [RULE6] long form, select in low bits
            16'b1011_1111_0000_1???: begin
                d.op     = OP_LOAD_AUX_LONG;
                d.words  = WRD_TWO;
                d.cycles = CYC_TWO;
                d.auxSel = d.word[AUX_LONG_LSB +: AUX_SEL_W];
            end
            // [RULE5] memory and short forms
            16'b0000_0???_????_????: begin
                d.op     = OP_LOAD_AUX_MEM;
                d.cycles = CYC_TWO;
            end
            16'b1011_0???_????_????: begin
                d.op     = OP_LOAD_AUX_SHORT;
                d.cycles = CYC_TWO;
                d.imm    = dod_word_t'(d.word[SHORT_IMM_W-1:0]);
            end
            // [RULE7] page pointer loads
            16'h0d??: begin
                d.op     = OP_LOAD_PAGE_MEM;
                d.cycles = CYC_TWO;
            end
            16'b1011_110?_????_????: begin
                d.op     = OP_LOAD_PAGE_IMM;
                d.cycles = CYC_TWO;
                d.imm    = dod_word_t'(d.word[PAGE_IMM_W-1:0]);
            end
            // [RULE8] status loads
            16'h0e??, 16'h0f??: begin
                d.op     = d.word[8] ? OP_LOAD_STATUS_ONE : OP_LOAD_STATUS_ZERO;
                d.cycles = CYC_TWO;
            end
            // [RULE9] [RULE10] operand register family
            16'h73??: d.op = OP_LOAD_MULT_OPERAND;
            16'h70??: d.op = OP_LOAD_OPERAND_ACCUMULATE;
            16'h72??: d.op = OP_LOAD_OPERAND_ACC_MOVE;
            16'h71??: d.op = OP_LOAD_OPERAND_STORE_PRODUCT;
            16'h74??: d.op = OP_LOAD_OPERAND_SUBTRACT;
            // [RULE11] two words, three cycles
            16'ha2??, 16'ha3??: begin
                d.op     = d.word[8] ? OP_MULTIPLY_ACCUMULATE_MOVE : OP_MULTIPLY_ACCUMULATE;
                d.words  = WRD_TWO;
                d.cycles = CYC_THREE;
            end
            // [RULE12] pointer, no-op, modify
            16'h8b00: d.op = OP_NO_OPERATION;
            16'b1000_1011_1000_1???: begin
                d.op     = OP_SELECT_AUX_POINTER;
                d.auxSel = d.word[AUX_LONG_LSB +: AUX_SEL_W];
            end
            16'h8b??: d.op = OP_MODIFY_AUX_REG;
            // [RULE13] [RULE14] [RULE15] multiplies
            16'h54??: d.op = OP_MULTIPLY_OP;
            16'b110?_????_????_????: begin
                d.op  = OP_MULTIPLY_IMM;
                d.imm = dod_word_t'(d.word[MULT_IMM_W-1:0]);
            end
            16'h50??: d.op = OP_MULTIPLY_ADD_PREVIOUS;
            16'h51??: d.op = OP_MULTIPLY_SUB_PREVIOUS;
            16'h55??: d.op = OP_MULTIPLY_UNSIGNED;
            // [RULE16] normalize
            16'ha0??: d.op = OP_NORMALIZE_ACC;
            // [RULE17] OR forms
            16'h6d??: d.op = OP_OR_ACC;
            16'hbe82: begin
                d.op     = OP_OR_IMM_SHIFT16;
                d.words  = WRD_TWO;
                d.cycles = CYC_TWO;
            end
            // [RULE18] product, negate, soft interrupt
            16'hbe03: d.op = OP_PRODUCT_TO_ACC;
            16'hbe02: d.op = OP_NEGATE_ACC;
            16'hbe52: begin
                d.op     = OP_SOFT_NMI;
                d.cycles = CYC_FOUR;
            end
            default: d.op = OP_NONE;
        endcase
    end

endmodule

// >>> dod_cycle_timer.sv
`timescale 1ns/100ps
module dod_cycle_timer
    import dod_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Load and tick
    dod_dec_if.tmr   t
);

    typedef struct packed {
        dod_cyc_t count;
    } dod_tmr_t;

    dod_tmr_t s_r;
    dod_tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (t.load) begin
            s_nxt.count = t.loadValue;
        end else if (s_r.count != CYC_NONE) begin
            s_nxt.count = s_r.count - CYC_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '{count: CYC_NONE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign t.count    = s_r.count;
    assign t.lastTick = (s_r.count == CYC_ONE);

endmodule

// >>> dod_dec_if.sv
`timescale 1ns/100ps
interface dod_dec_if;
    import dod_pkg::*;

    dod_word_t  word;
    dod_op_t    op;
    dod_words_t words;
    dod_cyc_t   cycles;
    logic [2:0] auxSel;
    logic [7:0] addr;
    dod_word_t  imm;
    logic       shiftFromOperand;
    logic       load;
    dod_cyc_t   loadValue;
    dod_cyc_t   count;
    logic       lastTick;

    modport dec (input word, output op, words, cycles, auxSel, addr, imm, shiftFromOperand);
    modport tmr (input load, loadValue, output count, lastTick);
    modport core (output word, load, loadValue,
                  input op, words, cycles, auxSel, addr, imm, shiftFromOperand, count, lastTick);
endinterface

// >>> dod_opcode_decoder.sv
`timescale 1ns/100ps
// What this block does
// [RULE1] 0xb9 prefix loads 8-bit immediate into low accumulator; zero means clear.
// [RULE2] 0x6a prefix clears low half, loads high half from memory, one cycle.
// [RULE3] 0x69 prefix clears accumulator, loads low half without sign extension.
// [RULE4] 0x6b prefix loads accumulator shifted by the operand register.
// [RULE5] Aux register load from memory or short immediate, one word, two cycles.
// [RULE6] 0xbf08-0xbf0f loads aux register from second word, two words, two cycles.
// [RULE7] Page pointer from memory or 9-bit immediate, one word, two cycles.
// [RULE8] 0x0e and 0x0f load status registers zero and one, two cycles.
// [RULE9] 0x73 loads operand register; 0x70 also accumulates previous product.
// [RULE10] 0x72 accumulates and moves, 0x71 stores product, 0x74 subtracts.
// [RULE11] 0xa2 and 0xa3 multiply-accumulate, two words, three cycles.
// [RULE12] 0x8b88-0x8b8f selects aux pointer, 0x8b00 is no-op, other 0x8b modify.
// [RULE13] 0x54 multiplies by data word; top bits 110 multiply by 13-bit immediate.
// [RULE14] 0x50 multiplies and adds previous product, one cycle.
// [RULE15] 0x51 multiplies and subtracts previous product; 0x55 multiplies unsigned.
// [RULE16] 0xa0 prefix normalizes the accumulator, one word, one cycle.
// [RULE17] 0x6d ORs data word; 0xbe82 ORs constant shifted by 16, two words.
// [RULE18] 0xbe03 product to accumulator, 0xbe02 negate, 0xbe52 soft interrupt, four.
// [RULE19] Second word becomes the constant; issue waits out the cycle count.
module dod_opcode_decoder
    import dod_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Program fetch side
    input  wire logic       fetchValid,
    input  wire dod_word_t  fetchWord,
    output logic            fetchReady,
    // Decoded instruction
    output logic            opValid,
    output dod_op_t         opKind,
    output logic [2:0]      opAuxSel,
    output logic [7:0]      opAddr,
    output dod_word_t       opImm,
    output dod_word_t       opConst,
    output dod_words_t      opWords,
    output dod_cyc_t        opCycles,
    output logic            opShiftFromOperand
);

    dod_dec_if  d ();
    dod_core_t  st_r;
    dod_core_t  st_nxt;
    logic       take;
    dod_cyc_t   holdCnt;

    dod_classify u_classify (
        .d (d.dec)
    );

    dod_cycle_timer u_timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .t       (d.tmr)
    );

    // Cycles still owed once the last word of an instruction is in
    function automatic dod_cyc_t holdOf(input dod_words_t w, input dod_cyc_t c);
        holdOf = c - dod_cyc_t'(w);
    endfunction

    assign take = fetchValid && st_r.ready;

    always_comb begin
        st_nxt      = st_r;
        d.word      = fetchWord;
        d.load      = 1'b0;
        d.loadValue = CYC_NONE;
        holdCnt     = CYC_NONE;
        st_nxt.opValid = 1'b0;
        case (st_r.state)
            ST_IDLE: begin
                if (take) begin
                    st_nxt.op               = d.op;
                    st_nxt.auxSel           = d.auxSel;
                    st_nxt.addr             = d.addr;
                    st_nxt.imm              = d.imm;
                    st_nxt.words            = d.words;
                    st_nxt.cycles           = d.cycles;
                    st_nxt.shiftFromOperand = d.shiftFromOperand;
                    st_nxt.constWord        = 16'h0000;
                    // [RULE19] wait for the constant
                    if (d.words == WRD_TWO) begin
                        st_nxt.state = ST_CONST;
                    end else begin
                        st_nxt.opValid = 1'b1;
                        holdCnt        = holdOf(d.words, d.cycles);
                    end
                end
            end
            ST_CONST: begin
                // [RULE6] [RULE11] [RULE17] constant word
                if (take) begin
                    st_nxt.constWord = fetchWord;
                    st_nxt.opValid   = 1'b1;
                    st_nxt.state     = ST_IDLE;
                    holdCnt          = holdOf(st_r.words, st_r.cycles);
                end
            end
            ST_HOLD: begin
                // [RULE19] release after the owed cycles
                if (d.lastTick) begin
                    st_nxt.ready = 1'b1;
                    st_nxt.state = ST_IDLE;
                end
            end
            default: begin
                st_nxt = CORE_RESET;
            end
        endcase
        // Back-to-back issue stays possible when nothing is owed
        if (holdCnt != CYC_NONE) begin
            st_nxt.ready = 1'b0;
            st_nxt.state = ST_HOLD;
            d.load       = 1'b1;
            d.loadValue  = holdCnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= CORE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fetchReady         = st_r.ready;
    assign opValid            = st_r.opValid;
    assign opKind             = st_r.op;
    assign opAuxSel           = st_r.auxSel;
    assign opAddr             = st_r.addr;
    assign opImm              = st_r.imm;
    assign opConst            = st_r.constWord;
    assign opWords            = st_r.words;
    assign opCycles           = st_r.cycles;
    assign opShiftFromOperand = st_r.shiftFromOperand;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic idleTake;
    assign idleTake = take && (st_r.state == ST_IDLE);

    chk_clear_acc: assert property ( // [RULE1]
        idleTake && fetchWord == 16'hb900
        |=> opValid && opKind == OP_CLEAR_ACC && opImm == 16'h0000)
        else $error("zero constant not decoded as clear");

    chk_acc_low_imm: assert property ( // [RULE1]
        idleTake && fetchWord[15:8] == 8'hb9 && fetchWord[7:0] != 8'h00
        |=> opKind == OP_LOAD_ACC_LOW && opImm[7:0] == $past(fetchWord[7:0]) && fetchReady)
        else $error("short accumulator load wrong");

    chk_zero_high: assert property ( // [RULE2]
        idleTake && fetchWord[15:8] == 8'h6a
        |=> opKind == OP_ZERO_LOAD_HIGH && opAddr == $past(fetchWord[7:0]) && fetchReady)
        else $error("zero low load high wrong");

    chk_zero_low: assert property ( // [RULE3]
        idleTake && fetchWord[15:8] == 8'h69
        |=> opKind == OP_ZERO_LOAD_LOW && opCycles == CYC_ONE && fetchReady)
        else $error("zero load low wrong");

    chk_operand_shift: assert property ( // [RULE4]
        opValid && opKind == OP_LOAD_ACC_OPERAND_SHIFT |-> opShiftFromOperand)
        else $error("operand shift flag missing");

    chk_aux_short_hold: assert property ( // [RULE5]
        idleTake && (fetchWord[15:11] == 5'h00 || fetchWord[15:11] == 5'h16)
        |=> opAuxSel == $past(fetchWord[10:8]) && !fetchReady ##1 fetchReady)
        else $error("aux load select or hold wrong");

    chk_aux_long_const: assert property ( // [RULE6]
        take && st_r.state == ST_CONST && opKind == OP_LOAD_AUX_LONG
        |=> opValid && opConst == $past(fetchWord) && fetchReady)
        else $error("aux long constant not issued");

    chk_page_imm: assert property ( // [RULE7]
        idleTake && fetchWord[15:9] == 7'h5e
        |=> opKind == OP_LOAD_PAGE_IMM && opImm == {7'h00, $past(fetchWord[8:0])} && !fetchReady
            ##1 fetchReady && !opValid)
        else $error("page immediate wrong");

    chk_status_hold: assert property ( // [RULE8]
        idleTake && fetchWord[15:9] == 7'h07
        |=> (opKind == OP_LOAD_STATUS_ZERO || opKind == OP_LOAD_STATUS_ONE)
            && !fetchReady ##1 fetchReady)
        else $error("status load wrong");

    chk_mult_operand: assert property ( // [RULE9]
        idleTake && fetchWord[15:8] == 8'h73 |=> opKind == OP_LOAD_MULT_OPERAND && fetchReady)
        else $error("operand load wrong");

    chk_operand_family: assert property ( // [RULE10]
        idleTake && fetchWord[15:8] == 8'h71 |=> opKind == OP_LOAD_OPERAND_STORE_PRODUCT)
        else $error("operand store product wrong");

    chk_mac_hold: assert property ( // [RULE11]
        opValid && (opKind == OP_MULTIPLY_ACCUMULATE || opKind == OP_MULTIPLY_ACCUMULATE_MOVE)
        |-> opWords == WRD_TWO && !fetchReady ##1 fetchReady)
        else $error("multiply accumulate timing wrong");

    chk_aux_pointer: assert property ( // [RULE12]
        idleTake && fetchWord[15:3] == 13'h1171
        |=> opKind == OP_SELECT_AUX_POINTER && opAuxSel == $past(fetchWord[2:0]))
        else $error("aux pointer select wrong");

    chk_no_operation: assert property ( // [RULE12]
        idleTake && fetchWord == 16'h8b00 |=> opKind == OP_NO_OPERATION && fetchReady)
        else $error("no operation wrong");

    chk_mult_imm: assert property ( // [RULE13]
        idleTake && fetchWord[15:13] == 3'h6
        |=> opKind == OP_MULTIPLY_IMM && opImm == {3'h0, $past(fetchWord[12:0])})
        else $error("multiply immediate wrong");

    chk_mult_add: assert property ( // [RULE14]
        idleTake && fetchWord[15:8] == 8'h50 |=> opKind == OP_MULTIPLY_ADD_PREVIOUS)
        else $error("multiply add wrong");

    chk_mult_unsigned: assert property ( // [RULE15]
        idleTake && fetchWord[15:8] == 8'h55 |=> opKind == OP_MULTIPLY_UNSIGNED && fetchReady)
        else $error("unsigned multiply wrong");

    chk_normalize: assert property ( // [RULE16]
        idleTake && fetchWord[15:8] == 8'ha0 |=> opKind == OP_NORMALIZE_ACC && opValid)
        else $error("normalize wrong");

    chk_or_long: assert property ( // [RULE17]
        idleTake && fetchWord == 16'hbe82 |=> !opValid && fetchReady && st_r.state == ST_CONST)
        else $error("long OR did not wait for constant");

    chk_nmi_hold: assert property ( // [RULE18]
        idleTake && fetchWord == 16'hbe52
        |=> opKind == OP_SOFT_NMI && !fetchReady [*3] ##1 fetchReady)
        else $error("soft interrupt hold wrong");

    chk_no_issue_busy: assert property ( // [RULE19]
        !fetchReady |=> !opValid)
        else $error("issue while holding");

    cov_one_word: cover property (idleTake ##1 opValid && fetchReady);
    cov_two_word: cover property (opValid && opKind == OP_MULTIPLY_ACCUMULATE);
    cov_nmi: cover property (opValid && opKind == OP_SOFT_NMI ##3 fetchReady);
    cov_back_to_back: cover property (opValid ##1 opValid);

endmodule

// >>> dod_opcode_decoder_load_mult_bench.sv
`timescale 1ns/100ps
module dod_opcode_decoder_load_mult_bench
    import dod_pkg::*;
;

    typedef struct packed {
        dod_op_t    kind;
        dod_words_t words;
        dod_cyc_t   cycles;
        logic [2:0] aux;
        dod_word_t  imm;
    } dod_exp_t;

    logic        ref_clk;
    logic        rst;
    logic        fetchValid;
    dod_word_t   fetchWord;
    logic        fetchReady;
    logic        opValid;
    dod_op_t     opKind;
    logic [2:0]  opAuxSel;
    logic [7:0]  opAddr;
    dod_word_t   opImm;
    dod_word_t   opConst;
    dod_words_t  opWords;
    dod_cyc_t    opCycles;
    logic        opShiftFromOperand;
    int          err_count;
    int          checked;
    int          cycleCount;
    logic [31:0] seed;

    // Opcode template in the upper half, randomised field mask in the lower half
    localparam logic [31:0] TBL [34] = '{
        32'hb900_00ff, 32'hb900_0000, 32'h6a00_00ff, 32'h6900_00ff,
        32'h6b00_00ff, 32'h0000_07ff, 32'hb000_07ff, 32'hbf08_0007,
        32'h0d00_00ff, 32'hbc00_01ff, 32'h0e00_00ff, 32'h0f00_00ff,
        32'h7300_00ff, 32'h7000_00ff, 32'h7200_00ff, 32'h7100_00ff,
        32'h7400_00ff, 32'ha200_00ff, 32'ha300_00ff, 32'h8b88_0007,
        32'h8b00_0000, 32'h8b01_007f, 32'h5400_00ff, 32'hc000_1fff,
        32'h5000_00ff, 32'h5100_00ff, 32'h5500_00ff, 32'ha000_00ff,
        32'h6d00_00ff, 32'hbe82_0000, 32'hbe03_0000, 32'hbe02_0000,
        32'hbe52_0000, 32'hbe32_0000
    };

    dod_opcode_decoder u_dut (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .fetchValid         (fetchValid),
        .fetchWord          (fetchWord),
        .fetchReady         (fetchReady),
        .opValid            (opValid),
        .opKind             (opKind),
        .opAuxSel           (opAuxSel),
        .opAddr             (opAddr),
        .opImm              (opImm),
        .opConst            (opConst),
        .opWords            (opWords),
        .opCycles           (opCycles),
        .opShiftFromOperand (opShiftFromOperand)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic dod_exp_t expect_of(input dod_word_t w);
        dod_exp_t e;
        e = '{kind: OP_NONE, words: WRD_ONE, cycles: CYC_ONE, aux: w[10:8], imm: 16'h0000};
        casez (w[15:8])
            8'b110?_????: e.kind = OP_MULTIPLY_IMM;
            8'hb9:        e.kind = (w[7:0] == 8'h00) ? OP_CLEAR_ACC : OP_LOAD_ACC_LOW;
            8'h6a:        e.kind = OP_ZERO_LOAD_HIGH;
            8'h69:        e.kind = OP_ZERO_LOAD_LOW;
            8'h6b:        e.kind = OP_LOAD_ACC_OPERAND_SHIFT;
            8'b0000_0???: e.kind = OP_LOAD_AUX_MEM;
            8'b1011_0???: e.kind = OP_LOAD_AUX_SHORT;
            8'hbf:        e.kind = (w[7:3] == 5'h01) ? OP_LOAD_AUX_LONG : OP_NONE;
            8'h0d:        e.kind = OP_LOAD_PAGE_MEM;
            8'b1011_110?: e.kind = OP_LOAD_PAGE_IMM;
            8'h0e:        e.kind = OP_LOAD_STATUS_ZERO;
            8'h0f:        e.kind = OP_LOAD_STATUS_ONE;
            8'h73:        e.kind = OP_LOAD_MULT_OPERAND;
            8'h70:        e.kind = OP_LOAD_OPERAND_ACCUMULATE;
            8'h72:        e.kind = OP_LOAD_OPERAND_ACC_MOVE;
            8'h71:        e.kind = OP_LOAD_OPERAND_STORE_PRODUCT;
            8'h74:        e.kind = OP_LOAD_OPERAND_SUBTRACT;
            8'ha2:        e.kind = OP_MULTIPLY_ACCUMULATE;
            8'ha3:        e.kind = OP_MULTIPLY_ACCUMULATE_MOVE;
            8'h8b:        e.kind = (w[7:3] == 5'h11) ? OP_SELECT_AUX_POINTER :
                                   (w[7:0] == 8'h00) ? OP_NO_OPERATION : OP_MODIFY_AUX_REG;
            8'h54:        e.kind = OP_MULTIPLY_OP;
            8'h50:        e.kind = OP_MULTIPLY_ADD_PREVIOUS;
            8'h51:        e.kind = OP_MULTIPLY_SUB_PREVIOUS;
            8'h55:        e.kind = OP_MULTIPLY_UNSIGNED;
            8'ha0:        e.kind = OP_NORMALIZE_ACC;
            8'h6d:        e.kind = OP_OR_ACC;
            8'hbe:        e.kind = (w[7:0] == 8'h82) ? OP_OR_IMM_SHIFT16 :
                                   (w[7:0] == 8'h03) ? OP_PRODUCT_TO_ACC :
                                   (w[7:0] == 8'h02) ? OP_NEGATE_ACC :
                                   (w[7:0] == 8'h52) ? OP_SOFT_NMI : OP_NONE;
            default:      e.kind = OP_NONE;
        endcase
        if (e.kind inside {OP_LOAD_AUX_LONG, OP_OR_IMM_SHIFT16, OP_MULTIPLY_ACCUMULATE,
                           OP_MULTIPLY_ACCUMULATE_MOVE}) e.words = WRD_TWO;
        if (e.kind inside {OP_LOAD_AUX_MEM, OP_LOAD_AUX_SHORT, OP_LOAD_AUX_LONG, OP_LOAD_PAGE_MEM,
                           OP_LOAD_PAGE_IMM, OP_LOAD_STATUS_ZERO, OP_LOAD_STATUS_ONE,
                           OP_OR_IMM_SHIFT16}) e.cycles = CYC_TWO;
        if (e.kind inside {OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_ACCUMULATE_MOVE})
            e.cycles = CYC_THREE;
        if (e.kind == OP_SOFT_NMI) e.cycles = CYC_FOUR;
        if (e.kind inside {OP_LOAD_AUX_LONG, OP_SELECT_AUX_POINTER}) e.aux = w[2:0];
        if (e.kind inside {OP_LOAD_ACC_LOW, OP_LOAD_AUX_SHORT}) e.imm = {8'h00, w[7:0]};
        if (e.kind == OP_LOAD_PAGE_IMM) e.imm = {7'h00, w[8:0]};
        if (e.kind == OP_MULTIPLY_IMM) e.imm = {3'h0, w[12:0]};
        return e;
    endfunction

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Entered at a rising edge; returns at the edge that takes the word
    task automatic put(input dod_word_t w);
        int n;
        n = 0;
        fetchValid <= 1'b1;
        fetchWord  <= w;
        @(negedge ref_clk);
        while (fetchReady !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        check(n < 10, "word never taken");
        @(posedge ref_clk);
    endtask

    task automatic run(input dod_word_t w, input dod_word_t k);
        dod_exp_t e;
        int       hold;
        e = expect_of(w);
        put(w);
        if (e.words == WRD_TWO) put(k);
        fetchValid <= 1'b0;
        @(negedge ref_clk);
        check(opValid === 1'b1 && opKind === e.kind, "issue or kind");
        if (e.kind != OP_NONE) begin
            check(opWords === e.words && opCycles === e.cycles, "counts");
            check(opAuxSel === e.aux && opImm === e.imm && opAddr === w[7:0], "fields");
            check(opShiftFromOperand === (e.kind == OP_LOAD_ACC_OPERAND_SHIFT), "shf");
            check(opConst === ((e.words == WRD_TWO) ? k : 16'h0000), "constant");
            hold = int'(e.cycles) - int'(e.words);
            for (int i = 0; i < hold; i++) begin
                check(fetchReady === 1'b0, "issue not held");
                @(negedge ref_clk);
            end
            check(fetchReady === 1'b1, "ready after hold");
            @(negedge ref_clk);
            check(opValid === 1'b0, "issue pulse too long");
        end
        @(posedge ref_clk);
    endtask

    task automatic check_idle();
        check(fetchReady === 1'b1 && opValid === 1'b0 && opKind === OP_NONE &&
              opWords === WRD_ONE && opCycles === CYC_ONE, "reset state");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Hang guard: the full sequence needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 3000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        time       t0;
        dod_word_t w;
        err_count  = 0;
        checked    = 0;
        cycleCount = 0;
        seed       = 32'h0000c5d3;
        rst        = 1'b1;
        fetchValid = 1'b0;
        fetchWord  = 16'h0000;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check_idle();
        @(posedge ref_clk);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 34; i++) begin
                w = TBL[i][31:16] | (16'(rnd()) & TBL[i][15:0]);
                run(w, 16'(rnd()));
            end
        end
        // Constants that look like opcodes must never be decoded
        run(16'ha3c1, 16'hbe52);
        run(16'hbf0f, 16'hffff);
        t0 = $time;
        put(16'h7355);
        put(16'h54aa);
        check(($time - t0) == 64'd40, "back to back refused");
        fetchValid <= 1'b0;
        @(negedge ref_clk);
        check(opValid === 1'b1 && opKind === OP_MULTIPLY_OP, "second of pair");
        @(posedge ref_clk);
        // Reset while the constant of a two-word op is still owed
        put(16'ha2c3);
        fetchValid <= 1'b0;
        rst        <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check_idle();
        @(posedge ref_clk);
        run(16'h7311, 16'h0000);
        test_done();
    end
endmodule

// >>> dod_pkg.sv
package dod_pkg;

    localparam int AUX_SEL_LSB  = 8;
    localparam int AUX_LONG_LSB = 0;
    localparam int AUX_SEL_W    = 3;
    localparam int ADDR_W       = 8;
    localparam int SHORT_IMM_W  = 8;
    localparam int PAGE_IMM_W   = 9;
    localparam int MULT_IMM_W   = 13;

    typedef logic [15:0] dod_word_t;
    typedef logic [1:0]  dod_words_t;
    typedef logic [2:0]  dod_cyc_t;

    localparam dod_words_t WRD_ONE   = 2'h1;
    localparam dod_words_t WRD_TWO   = 2'h2;
    localparam dod_cyc_t   CYC_NONE  = 3'h0;
    localparam dod_cyc_t   CYC_ONE   = 3'h1;
    localparam dod_cyc_t   CYC_TWO   = 3'h2;
    localparam dod_cyc_t   CYC_THREE = 3'h3;
    localparam dod_cyc_t   CYC_FOUR  = 3'h4;

    typedef enum logic [5:0] {
        OP_NONE              = 6'h00,
        OP_LOAD_ACC_LOW      = 6'h01,
        OP_CLEAR_ACC         = 6'h02,
        OP_ZERO_LOAD_HIGH    = 6'h03,
        OP_ZERO_LOAD_LOW     = 6'h04,
        OP_LOAD_ACC_OPERAND_SHIFT = 6'h05,
        OP_LOAD_AUX_MEM      = 6'h06,
        OP_LOAD_AUX_SHORT    = 6'h07,
        OP_LOAD_AUX_LONG     = 6'h08,
        OP_LOAD_PAGE_MEM     = 6'h09,
        OP_LOAD_PAGE_IMM     = 6'h0a,
        OP_LOAD_STATUS_ZERO  = 6'h0b,
        OP_LOAD_STATUS_ONE   = 6'h0c,
        OP_LOAD_MULT_OPERAND = 6'h0d,
        OP_LOAD_OPERAND_ACCUMULATE = 6'h0e,
        OP_LOAD_OPERAND_ACC_MOVE   = 6'h0f,
        OP_LOAD_OPERAND_STORE_PRODUCT = 6'h10,
        OP_LOAD_OPERAND_SUBTRACT   = 6'h11,
        OP_MULTIPLY_ACCUMULATE     = 6'h12,
        OP_MULTIPLY_ACCUMULATE_MOVE = 6'h13,
        OP_SELECT_AUX_POINTER = 6'h14,
        OP_MODIFY_AUX_REG    = 6'h15,
        OP_NO_OPERATION      = 6'h16,
        OP_MULTIPLY_OP       = 6'h17,
        OP_MULTIPLY_IMM      = 6'h18,
        OP_MULTIPLY_ADD_PREVIOUS = 6'h19,
        OP_MULTIPLY_SUB_PREVIOUS = 6'h1a,
        OP_MULTIPLY_UNSIGNED = 6'h1b,
        OP_NORMALIZE_ACC     = 6'h1c,
        OP_OR_ACC            = 6'h1d,
        OP_OR_IMM_SHIFT16    = 6'h1e,
        OP_PRODUCT_TO_ACC    = 6'h1f,
        OP_NEGATE_ACC        = 6'h20,
        OP_SOFT_NMI          = 6'h21
    } dod_op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONST = 3'b010,
        ST_HOLD  = 3'b100
    } dod_state_t;

    typedef struct packed {
        dod_state_t  state;
        logic        ready;
        logic        opValid;
        dod_op_t     op;
        logic [2:0]  auxSel;
        logic [7:0]  addr;
        dod_word_t   imm;
        dod_word_t   constWord;
        dod_words_t  words;
        dod_cyc_t    cycles;
        logic        shiftFromOperand;
    } dod_core_t;

    localparam dod_core_t CORE_RESET = '{state: ST_IDLE, ready: 1'b1, op: OP_NONE,
                                         words: WRD_ONE, cycles: CYC_ONE, default: '0};

endpackage
